/* design/dtc_pkg.sv */
package dtc_pkg;

	localparam int NUM_TIMERS = 2;
	localparam int NUM_PINS   = 4;
	localparam int COUNT_W    = 13;
	localparam int LOW_W      = 5;

	// Byte addresses of the registers.
	localparam logic [7:0] OFF_CTRL     = 8'h00;
	localparam logic [7:0] OFF_MODE     = 8'h04;
	localparam logic [7:0] OFF_PRESCALE = 8'h08;
	localparam logic [7:0] OFF_EXTCFG   = 8'h0c;
	localparam logic [7:0] OFF_IRQ_EN   = 8'h10;
	localparam logic [7:0] OFF_STATUS   = 8'h14;
	localparam logic [7:0] OFF_T0_LOW   = 8'h18;
	localparam logic [7:0] OFF_T0_HIGH  = 8'h1c;
	localparam logic [7:0] OFF_T1_LOW   = 8'h20;
	localparam logic [7:0] OFF_T1_HIGH  = 8'h24;

	// Control: run bit of timer n at bit n.
	localparam int CTRL_RUN_POS     = 0;
	// Mode: timer n field starts at MODE_STRIDE*n.
	localparam int MODE_STRIDE      = 4;
	localparam int MODE_SEL_POS     = 0;
	localparam int MODE_CSEL_POS    = 2;
	localparam int MODE_GATE_POS    = 3;
	localparam logic [1:0] MODE_13BIT = 2'h0;
	// Prescale control fields.
	localparam int PRE_SCALE_POS    = 0;
	localparam int PRE_SYSSEL_POS   = 2;
	// External input configuration: polarity of gate n at bit n.
	localparam int EXT_POL_POS      = 0;
	// Pin vector positions.
	localparam int PIN_COUNT0       = 0;
	localparam int PIN_COUNT1       = 1;
	localparam int PIN_GATE_ENABLE_BIT        = 2;
	localparam int PIN_GATE1        = 3;

	// Prescaler divide ratios per clock scale code.
	localparam logic [5:0] DIV_SCALE0 = 6'h0c;
	localparam logic [5:0] DIV_SCALE1 = 6'h04;
	localparam logic [5:0] DIV_SCALE2 = 6'h30;
	localparam logic [5:0] DIV_SCALE3 = 6'h08;

	localparam logic [7:0] RST_BYTE   = 8'h00;
	localparam logic [1:0] RESP_OKAY  = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage : dtc_pkg

/* design/dtc_pin_sync.sv */
`timescale 1ns/1ns
module dtc_pin_sync (
	// Clock and reset
	input  logic                         aclk,
	input  logic                         aresetn,
	// Raw pins
	input  logic [dtc_pkg::NUM_PINS-1:0] pin_in,
	// Synchronised levels and falling-edge pulses
	output logic [dtc_pkg::NUM_PINS-1:0] pin_level,
	output logic [dtc_pkg::NUM_PINS-1:0] pin_fall
);

	logic [dtc_pkg::NUM_PINS-1:0] meta;
	logic [dtc_pkg::NUM_PINS-1:0] sync;
	logic [dtc_pkg::NUM_PINS-1:0] last;

	// Only the second stage feeds the edge detector.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			meta <= '0;
			sync <= '0;
			last <= '0;
		end else begin
			meta <= pin_in;
			sync <= meta;
			last <= sync;
		end
	end

	assign pin_level = sync;
	assign pin_fall  = last & ~sync;

endmodule : dtc_pin_sync

/* design/dtc_prescaler.sv */
`timescale 1ns/1ns
module dtc_prescaler (
	// Clock and reset
	input  logic       aclk,
	input  logic       aresetn,
	// Clock scale select
	input  logic [1:0] scale,
	// One-cycle tick at the divided rate
	output logic       tick
);

	logic [5:0] div;
	logic [5:0] cnt;

	always_comb begin
		if (scale == 2'h0) begin
			div = dtc_pkg::DIV_SCALE0;
		end else if (scale == 2'h1) begin
			div = dtc_pkg::DIV_SCALE1;
		end else if (scale == 2'h2) begin
			div = dtc_pkg::DIV_SCALE2;
		end else begin
			div = dtc_pkg::DIV_SCALE3;
		end
	end

	// A change of scale may stretch one period; never shortens below one.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cnt  <= 6'h00;
			tick <= 1'b0;
		end else if (cnt >= div - 6'h01) begin
			cnt  <= 6'h00;
			tick <= 1'b1;
		end else begin
			cnt  <= cnt + 6'h01;
			tick <= 1'b0;
		end
	end

endmodule : dtc_prescaler

/* design/dtc_timer.sv */
`timescale 1ns/1ns
module dtc_timer (
	// Clock and reset
	input  logic        aclk,
	input  logic        aresetn,
	// AXI4-Lite write address
	input  logic [7:0]  awaddr,
	input  logic        awvalid,
	output logic        awready,
	// AXI4-Lite write data
	input  logic [31:0] wdata,
	input  logic [3:0]  wstrb,
	input  logic        wvalid,
	output logic        wready,
	// AXI4-Lite write response
	output logic [1:0]  bresp,
	output logic        bvalid,
	input  logic        bready,
	// AXI4-Lite read address
	input  logic [7:0]  araddr,
	input  logic        arvalid,
	output logic        arready,
	// AXI4-Lite read data
	output logic [31:0] rdata,
	output logic [1:0]  rresp,
	output logic        rvalid,
	input  logic        rready,
	// External count and gate pins
	input  logic        external_count_pin0,
	input  logic        external_count_pin1,
	input  logic        gate_input_zero,
	input  logic        gate_input_one,
	// Interrupt
	output logic        irq
);

	localparam int NT = dtc_pkg::NUM_TIMERS;

	// Software-visible registers.
	logic [7:0] timer_control_register;
	logic [7:0] timer_mode_register;
	logic [7:0] clock_prescale_control;
	logic [7:0] external_input_config_register;
	logic [7:0] interrupt_enable_register;
	logic [7:0] overflow_status;
	logic [7:0] count_low  [NT];
	logic [7:0] count_high [NT];

	// Bus state.
	logic        aw_full;
	logic [7:0]  aw_addr_q;
	logic        w_full;
	logic [31:0] w_data_q;
	logic [3:0]  w_strb_q;
	logic        wr_do;
	logic        wr_lane0;
	logic        wr_hit;

	// Timer datapath.
	logic [dtc_pkg::NUM_PINS-1:0] pin_level;
	logic [dtc_pkg::NUM_PINS-1:0] pin_fall;
	logic [dtc_pkg::NUM_PINS-1:0] pin_raw;
	logic                         presc_tick;
	logic [NT-1:0]                step;
	logic [NT-1:0]                wrap;
	logic [NT-1:0]                sw_touch;
	logic [7:0]                   next_status;

	// Increment of the split count; returns the carry out in bit 13.
	function automatic logic [dtc_pkg::COUNT_W:0] count_inc(
		input logic [7:0] hi,
		input logic [7:0] lo
	);
		logic [dtc_pkg::COUNT_W:0] full;
		full = {1'b0, hi, lo[dtc_pkg::LOW_W-1:0]};
		return full + 14'h0001;
	endfunction : count_inc

	// Register decode used by both the write and the read path.
	function automatic logic addr_mapped(input logic [7:0] a);
		logic hit;
		hit = 1'b0;
		if (a == dtc_pkg::OFF_CTRL) begin
			hit = 1'b1;
		end else if (a == dtc_pkg::OFF_MODE) begin
			hit = 1'b1;
		end else if (a == dtc_pkg::OFF_PRESCALE) begin
			hit = 1'b1;
		end else if (a == dtc_pkg::OFF_EXTCFG) begin
			hit = 1'b1;
		end else if (a == dtc_pkg::OFF_IRQ_EN) begin
			hit = 1'b1;
		end else if (a == dtc_pkg::OFF_STATUS) begin
			hit = 1'b1;
		end else if (a == dtc_pkg::OFF_T0_LOW) begin
			hit = 1'b1;
		end else if (a == dtc_pkg::OFF_T0_HIGH) begin
			hit = 1'b1;
		end else if (a == dtc_pkg::OFF_T1_LOW) begin
			hit = 1'b1;
		end else if (a == dtc_pkg::OFF_T1_HIGH) begin
			hit = 1'b1;
		end
		return hit;
	endfunction : addr_mapped

	assign pin_raw = {gate_input_one, gate_input_zero,
		external_count_pin1, external_count_pin0};

	dtc_pin_sync u_sync (
		.aclk      (aclk),
		.aresetn   (aresetn),
		.pin_in    (pin_raw),
		.pin_level (pin_level),
		.pin_fall  (pin_fall)
	);

	dtc_prescaler u_presc (
		.aclk    (aclk),
		.aresetn (aresetn),
		.scale   (clock_prescale_control[dtc_pkg::PRE_SCALE_POS +: 2]),
		.tick    (presc_tick)
	);

	// ---------------------------------------------------------------
	// AXI4-Lite write path: address and data are held independently,
	// the register write happens once both are present.
	// ---------------------------------------------------------------
	assign awready  = !aw_full && !bvalid;
	assign wready   = !w_full && !bvalid;
	assign wr_do    = aw_full && w_full && !bvalid;
	assign wr_hit   = addr_mapped(aw_addr_q);
	assign wr_lane0 = wr_do && wr_hit && w_strb_q[0];

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_full   <= 1'b0;
			aw_addr_q <= 8'h00;
		end else if (awvalid && awready) begin
			aw_full   <= 1'b1;
			aw_addr_q <= awaddr;
		end else if (wr_do) begin
			aw_full   <= 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			w_full   <= 1'b0;
			w_data_q <= 32'h0000_0000;
			w_strb_q <= 4'h0;
		end else if (wvalid && wready) begin
			w_full   <= 1'b1;
			w_data_q <= wdata;
			w_strb_q <= wstrb;
		end else if (wr_do) begin
			w_full   <= 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			bvalid <= 1'b0;
			bresp  <= dtc_pkg::RESP_OKAY;
		end else if (wr_do) begin
			bvalid <= 1'b1;
			bresp  <= wr_hit ? dtc_pkg::RESP_OKAY : dtc_pkg::RESP_SLVERR;
		end else if (bready) begin
			bvalid <= 1'b0;
		end
	end

	// Plain configuration registers.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			timer_control_register         <= dtc_pkg::RST_BYTE;
			timer_mode_register            <= dtc_pkg::RST_BYTE;
			clock_prescale_control         <= dtc_pkg::RST_BYTE;
			external_input_config_register <= dtc_pkg::RST_BYTE;
			interrupt_enable_register      <= dtc_pkg::RST_BYTE;
		end else if (wr_lane0) begin
			if (aw_addr_q == dtc_pkg::OFF_CTRL) begin
				timer_control_register <= w_data_q[7:0];
			end else if (aw_addr_q == dtc_pkg::OFF_MODE) begin
				timer_mode_register <= w_data_q[7:0];
			end else if (aw_addr_q == dtc_pkg::OFF_PRESCALE) begin
				clock_prescale_control <= w_data_q[7:0];
			end else if (aw_addr_q == dtc_pkg::OFF_EXTCFG) begin
				external_input_config_register <= w_data_q[7:0];
			end else if (aw_addr_q == dtc_pkg::OFF_IRQ_EN) begin
				interrupt_enable_register <= w_data_q[7:0];
			end
		end
	end

	// ---------------------------------------------------------------
	// Count enable per timer.
	// ---------------------------------------------------------------
	always_comb begin
		int         b;
		logic       run;
		logic       gate_en;
		logic       csel;
		logic       syssel;
		logic       gate_act;
		logic       src;
		logic [1:0] mode;
		b        = 0;
		run      = 1'b0;
		gate_en  = 1'b0;
		csel     = 1'b0;
		syssel   = 1'b0;
		gate_act = 1'b0;
		src      = 1'b0;
		mode     = 2'h0;
		step     = '0;
		for (int i = 0; i < NT; i++) begin
			b       = dtc_pkg::MODE_STRIDE * i;
			run     = timer_control_register[dtc_pkg::CTRL_RUN_POS + i];
			mode    = timer_mode_register[b + dtc_pkg::MODE_SEL_POS +: 2];
			csel    = timer_mode_register[b + dtc_pkg::MODE_CSEL_POS];
			gate_en = timer_mode_register[b + dtc_pkg::MODE_GATE_POS];
			syssel  = clock_prescale_control[dtc_pkg::PRE_SYSSEL_POS + i];
			// Active level is the polarity bit: 1 = high, 0 = low.
			gate_act = pin_level[dtc_pkg::PIN_GATE_ENABLE_BIT + i] ==
				external_input_config_register[dtc_pkg::EXT_POL_POS + i];
			if (csel) begin
				src = pin_fall[dtc_pkg::PIN_COUNT0 + i];
			end else if (syssel) begin
				src = 1'b1;
			end else begin
				src = presc_tick;
			end
			step[i] = src && run && (!gate_en || gate_act) &&
				(mode == dtc_pkg::MODE_13BIT);
		end
	end

	// ---------------------------------------------------------------
	// Count registers. A software write to either byte of a timer
	// takes that cycle's step away, so the written value is exact.
	// ---------------------------------------------------------------
	always_comb begin
		sw_touch[0] = wr_lane0 && (aw_addr_q == dtc_pkg::OFF_T0_LOW ||
			aw_addr_q == dtc_pkg::OFF_T0_HIGH);
		sw_touch[1] = wr_lane0 && (aw_addr_q == dtc_pkg::OFF_T1_LOW ||
			aw_addr_q == dtc_pkg::OFF_T1_HIGH);
	end

	always_ff @(posedge aclk) begin
		logic [dtc_pkg::COUNT_W:0] nxt;
		nxt = '0;
		if (!aresetn) begin
			for (int i = 0; i < NT; i++) begin
				count_low[i]  <= dtc_pkg::RST_BYTE;
				count_high[i] <= dtc_pkg::RST_BYTE;
			end
		end else begin
			for (int i = 0; i < NT; i++) begin
				nxt = count_inc(count_high[i], count_low[i]);
				if (sw_touch[i]) begin
					if (aw_addr_q == dtc_pkg::OFF_T0_LOW + 8'(8 * i)) begin
						count_low[i] <= w_data_q[7:0];
					end else begin
						count_high[i] <= w_data_q[7:0];
					end
				end else if (step[i]) begin
					// Bits 7..5 of the low byte keep what software wrote.
					count_low[i][dtc_pkg::LOW_W-1:0] <=
						nxt[dtc_pkg::LOW_W-1:0];
					count_high[i] <= nxt[dtc_pkg::COUNT_W-1:dtc_pkg::LOW_W];
				end
			end
		end
	end

	always_comb begin
		logic [dtc_pkg::COUNT_W:0] inc;
		inc  = '0;
		wrap = '0;
		for (int i = 0; i < NT; i++) begin
			inc     = count_inc(count_high[i], count_low[i]);
			wrap[i] = step[i] && !sw_touch[i] &&
				inc[dtc_pkg::COUNT_W];
		end
	end

	// ---------------------------------------------------------------
	// Overflow flags: write one to clear, a new overflow wins.
	// ---------------------------------------------------------------
	always_comb begin
		next_status = overflow_status;
		if (wr_lane0 && aw_addr_q == dtc_pkg::OFF_STATUS) begin
			next_status = overflow_status & ~w_data_q[7:0];
		end
		next_status[NT-1:0] = next_status[NT-1:0] | wrap;
		next_status[7:NT] = '0;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			overflow_status <= dtc_pkg::RST_BYTE;
		end else begin
			overflow_status <= next_status;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			irq <= 1'b0;
		end else begin
			irq <= |(overflow_status & interrupt_enable_register);
		end
	end

	// ---------------------------------------------------------------
	// AXI4-Lite read path.
	// ---------------------------------------------------------------
	assign arready = !rvalid;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rvalid <= 1'b0;
			rdata  <= 32'h0000_0000;
			rresp  <= dtc_pkg::RESP_OKAY;
		end else if (arvalid && arready) begin
			rvalid <= 1'b1;
			rresp  <= addr_mapped(araddr) ? dtc_pkg::RESP_OKAY
				: dtc_pkg::RESP_SLVERR;
			if (araddr == dtc_pkg::OFF_CTRL) begin
				rdata <= {24'h000000, timer_control_register};
			end else if (araddr == dtc_pkg::OFF_MODE) begin
				rdata <= {24'h000000, timer_mode_register};
			end else if (araddr == dtc_pkg::OFF_PRESCALE) begin
				rdata <= {24'h000000, clock_prescale_control};
			end else if (araddr == dtc_pkg::OFF_EXTCFG) begin
				rdata <= {24'h000000, external_input_config_register};
			end else if (araddr == dtc_pkg::OFF_IRQ_EN) begin
				rdata <= {24'h000000, interrupt_enable_register};
			end else if (araddr == dtc_pkg::OFF_STATUS) begin
				rdata <= {24'h000000, overflow_status};
			end else if (araddr == dtc_pkg::OFF_T0_LOW) begin
				rdata <= {24'h000000, count_low[0]};
			end else if (araddr == dtc_pkg::OFF_T0_HIGH) begin
				rdata <= {24'h000000, count_high[0]};
			end else if (araddr == dtc_pkg::OFF_T1_LOW) begin
				rdata <= {24'h000000, count_low[1]};
			end else if (araddr == dtc_pkg::OFF_T1_HIGH) begin
				rdata <= {24'h000000, count_high[1]};
			end else begin
				rdata <= 32'h0000_0000;
			end
		end else if (rready) begin
			rvalid <= 1'b0;
		end
	end

endmodule : dtc_timer

/* testbench/dtc_pin_model.sv */
`timescale 1ns/1ns
module dtc_pin_model (
	// Clock
	input  logic       aclk,
	// Count and gate pins toward the timer
	output logic [1:0] cnt,
	output logic [1:0] gate
);
	initial begin
		cnt = 2'h3;
		gate = 2'h2;
	end

	// The low level is held four clocks and the high level at least five, beyond the two-flop synchroniser.
	task automatic pulse(input int ch, input int n);
		repeat (n) begin
			@(posedge aclk);
			cnt[ch] <= 1'b0;
			repeat (4) @(posedge aclk);
			cnt[ch] <= 1'b1;
			repeat (4) @(posedge aclk);
		end
	endtask : pulse

	task automatic set_gate(input int ch, input logic v);
		@(posedge aclk);
		gate[ch] <= v;
	endtask : set_gate
endmodule : dtc_pin_model

/* testbench/dtc_timer_sva.sv */
`timescale 1ns/1ns
module dtc_timer_sva (
	// Clock and reset
	input logic        aclk,
	input logic        aresetn,
	// Register bus
	input logic [7:0]  awaddr,
	input logic        awvalid,
	input logic        awready,
	input logic [31:0] wdata,
	input logic [3:0]  wstrb,
	input logic        wvalid,
	input logic        wready,
	input logic [1:0]  bresp,
	input logic        bvalid,
	input logic        bready,
	input logic [7:0]  araddr,
	input logic        arvalid,
	input logic        arready,
	input logic [31:0] rdata,
	input logic [1:0]  rresp,
	input logic        rvalid,
	input logic        rready,
	// Interrupt
	input logic        irq
);
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);

	// Shadow mask, taken one edge after the write lands, as irq lags too.
	logic [7:0] h_addr;
	logic [1:0] h_data;
	logic       h_strb;
	logic       h_bq;
	logic [1:0] h_mask;
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			h_addr <= 8'h00;
			h_data <= 2'h0;
			h_strb <= 1'b0;
			h_bq <= 1'b0;
			h_mask <= 2'h0;
		end else begin
			if (awvalid && awready)
				h_addr <= awaddr;
			if (wvalid && wready) begin
				h_data <= wdata[1:0];
				h_strb <= wstrb[0];
			end
			h_bq <= bvalid;
			if (bvalid && !h_bq && h_strb && h_addr == dtc_pkg::OFF_IRQ_EN)
				h_mask <= h_data;
		end
	end

	a_read_pad: assert property (rvalid |-> rdata[31:8] == 24'h0)
		else $error("read data upper bits not zero");
	a_read_hold: assert property (
		rvalid && !rready |=> rvalid && $stable(rdata))
		else $error("read data dropped before rready");
	a_read_unmap: assert property (
		arvalid && arready && araddr > dtc_pkg::OFF_T1_HIGH
		|=> rresp == dtc_pkg::RESP_SLVERR && rdata == 32'h0)
		else $error("unmapped read not refused");
	a_write_resp: assert property (
		awvalid && awready && wvalid && wready |=> !bvalid ##1 bvalid)
		else $error("write response latency wrong");
	a_write_hold: assert property (
		bvalid && !bready |=> bvalid && $stable(bresp))
		else $error("write response dropped before bready");
	a_bus_refuse: assert property (bvalid |-> !awready && !wready)
		else $error("write accepted while response pending");
	a_irq_mask: assert property (h_mask == 2'h0 |-> !irq)
		else $error("irq high with all sources masked");
	a_irq_rise: assert property ($rose(irq) |-> h_mask != 2'h0)
		else $error("irq rose without an enabled source");
	a_irq_fall: assert property ($fell(irq) |-> $past(bvalid))
		else $error("irq fell without a register write");

	c_irq_rise: cover property ($rose(irq));
	c_irq_fall: cover property ($fell(irq));
	c_unmapped: cover property (rvalid && rresp == dtc_pkg::RESP_SLVERR);
endmodule : dtc_timer_sva

bind dtc_timer dtc_timer_sva u_sva (.*);

/* testbench/tb.sv */
`timescale 1ns/1ns
module tb;
	logic        aclk, aresetn, irq;
	logic        awvalid, awready, wvalid, wready, bvalid, bready;
	logic        arvalid, arready, rvalid, rready;
	logic [7:0]  awaddr, araddr, lo, hi;
	logic [31:0] wdata, rdata, rd;
	logic [3:0]  wstrb;
	logic [1:0]  bresp, rresp, rsp, rrs, cnt, gate;
	int          errors, checks, d;

	localparam logic [7:0] RA [6] = '{dtc_pkg::OFF_T0_LOW,
		dtc_pkg::OFF_T0_HIGH, dtc_pkg::OFF_T1_LOW, dtc_pkg::OFF_T1_HIGH,
		dtc_pkg::OFF_EXTCFG, 8'h28};
	localparam logic [7:0] RW [6] = '{8'he5, 8'h5a, 8'h1f, 8'hff, 8'h03, 8'h77};
	localparam logic [7:0] RE [6] = '{8'he5, 8'h5a, 8'h1f, 8'hff, 8'h03, 8'h00};
	localparam logic [1:0] RR [6] = '{2'h0, 2'h0, 2'h0, 2'h0, 2'h0, 2'h2};
	localparam int DIV [5] = '{1, 12, 4, 48, 8};

	initial begin
		aclk = 1'b0;
		forever #50 aclk = ~aclk;
	end

	dtc_timer u_dut (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr),
		.awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
		.wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
		.bready(bready), .araddr(araddr), .arvalid(arvalid),
		.arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
		.rready(rready), .external_count_pin0(cnt[0]),
		.external_count_pin1(cnt[1]), .gate_input_zero(gate[0]),
		.gate_input_one(gate[1]), .irq(irq));
	dtc_pin_model u_pins (.aclk(aclk), .cnt(cnt), .gate(gate));

	task automatic check(input string what, input logic [31:0] seen,
		input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			errors++;
			$display("[FAIL] %s expected %h seen %h", what, exp, seen);
		end
	endtask : check

	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		logic aw_done;
		logic w_done;
		aw_done = 1'b0;
		w_done = 1'b0;
		@(posedge aclk);
		awaddr <= a;
		wdata <= v;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		// Each channel is released at the edge at which its own ready is seen.
		while (!(aw_done && w_done)) begin
			@(posedge aclk);
			if (!aw_done && awready) begin
				aw_done = 1'b1;
				awvalid <= 1'b0;
			end
			if (!w_done && wready) begin
				w_done = 1'b1;
				wvalid <= 1'b0;
			end
		end
		do @(posedge aclk); while (!bvalid);
		rsp = bresp;
		bready <= 1'b0;
	endtask : wr

	task automatic rdr(input logic [7:0] a);
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do @(posedge aclk); while (!arready);
		arvalid <= 1'b0;
		do @(posedge aclk); while (!rvalid);
		rd = rdata;
		rrs = rresp;
		rready <= 1'b0;
	endtask : rdr

	task automatic complete_run;
		$display("checks %0d errors %0d", checks, errors);
		if (errors == 0 && checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : complete_run

	initial begin
		#3000000;
		errors++;
		complete_run();
	end

	initial begin
		aresetn = 1'b0;
		{awaddr, araddr, wdata} = '0;
		wstrb = 4'hf;
		{awvalid, wvalid, bready, arvalid, rready} = '0;
		repeat (5) @(posedge aclk);
		aresetn <= 1'b1;
		for (int i = 0; i < 6; i++) begin
			rdr(RA[i]);
			check("reset value", rd, 32'h0);
			wr(RA[i], {24'h0, RW[i]});
			check("write resp", {30'h0, rsp}, {30'h0, RR[i]});
			rdr(RA[i]);
			check("read back", rd, {24'h0, RE[i]});
			check("read resp", {30'h0, rrs}, {30'h0, RR[i]});
		end
		$display("register table done");
		// Gate 0 is active high and gate 1 active low, so a swap shows.
		wr(dtc_pkg::OFF_EXTCFG, 32'h1);
		for (int ch = 0; ch < 2; ch++) begin
			lo = ch ? dtc_pkg::OFF_T1_LOW : dtc_pkg::OFF_T0_LOW;
			hi = ch ? dtc_pkg::OFF_T1_HIGH : dtc_pkg::OFF_T0_HIGH;
			wr(dtc_pkg::OFF_MODE, 32'hc << (4 * ch));
			u_pins.set_gate(ch, ch[0]);
			wr(lo, 32'h1d);
			wr(hi, 32'hff);
			wr(dtc_pkg::OFF_IRQ_EN, 32'h1 << ch);
			wr(dtc_pkg::OFF_CTRL, 32'h1 << ch);
			u_pins.pulse(ch, 2);
			rdr(lo);
			check("gated hold", {27'h0, rd[4:0]}, 32'h1d);
			u_pins.set_gate(ch, !ch[0]);
			u_pins.pulse(ch, 3);
			repeat (3) @(posedge aclk);
			check("irq set", {31'h0, irq}, 32'h1);
			rdr(dtc_pkg::OFF_STATUS);
			check("overflow", rd, 32'h1 << ch);
			rdr(hi);
			check("high wrap", rd, 32'h0);
			wr(dtc_pkg::OFF_CTRL, 32'h0);
			u_pins.pulse(ch, 1);
			rdr(lo);
			check("low wrap", {27'h0, rd[4:0]}, 32'h0);
			wr(dtc_pkg::OFF_IRQ_EN, 32'h0);
			repeat (2) @(posedge aclk);
			check("irq masked", {31'h0, irq}, 32'h0);
			wr(dtc_pkg::OFF_STATUS, 32'h1 << ch);
			rdr(dtc_pkg::OFF_STATUS);
			check("flag cleared", rd, 32'h0);
		end
		$display("pin counting done");
		wr(dtc_pkg::OFF_MODE, 32'h0);
		for (int k = 0; k < 5; k++) begin
			wr(dtc_pkg::OFF_T0_LOW, 32'h0);
			wr(dtc_pkg::OFF_T0_HIGH, 32'h0);
			wr(dtc_pkg::OFF_PRESCALE, k == 0 ? 32'h4 : k - 1);
			wr(dtc_pkg::OFF_CTRL, 32'h1);
			repeat (96) @(posedge aclk);
			wr(dtc_pkg::OFF_CTRL, 32'h0);
			rdr(dtc_pkg::OFF_T0_LOW);
			d = rd[4:0];
			rdr(dtc_pkg::OFF_T0_HIGH);
			d += rd[7:0] * 32;
			d *= DIV[k];
			check("clock source", {31'h0, d >= 96 && d <= 104 + DIV[k]},
				32'h1);
		end
		$display("clock source done");
		// A mode other than the 13-bit one must hold the count.
		wr(dtc_pkg::OFF_MODE, 32'h1);
		wr(dtc_pkg::OFF_T0_LOW, 32'h0);
		wr(dtc_pkg::OFF_T0_HIGH, 32'h0);
		wr(dtc_pkg::OFF_PRESCALE, 32'h4);
		wr(dtc_pkg::OFF_CTRL, 32'h1);
		repeat (8) @(posedge aclk);
		wr(dtc_pkg::OFF_CTRL, 32'h0);
		rdr(dtc_pkg::OFF_T0_LOW);
		check("other mode hold", {27'h0, rd[4:0]}, 32'h0);
		$display("mode select done");
		wr(dtc_pkg::OFF_T0_HIGH, 32'h12);
		@(posedge aclk);
		aresetn <= 1'b0;
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		rdr(dtc_pkg::OFF_T0_HIGH);
		check("second reset", rd, 32'h0);
		$display("second reset done");
		complete_run();
	end
endmodule : tb
